// file: mcecc_map.vh
/*
 * Register map, field positions, bus size codes and reset values of the
 * crossbar policy and memory error reporting registers.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef MCECC_MAP_VH
`define MCECC_MAP_VH

// Byte addresses within the module
`define MC_ADDR_W 7
`define MC_OFF_USER_CTRL 7'h24
`define MC_OFF_ECC_CFG 7'h43
`define MC_OFF_ECC_FLAGS 7'h47
`define MC_OFF_FL_ADDR 7'h50
`define MC_OFF_FL_MATTR 7'h58
`define MC_OFF_FL_DATA 7'h5C
`define MC_OFF_RAM_ADDR 7'h60
`define MC_OFF_RAM_SMATTR 7'h64
`define MC_OFF_RAM_DATA 7'h6C

// Transfer size codes on the register bus
`define MC_SZ_BYTE 2'h0
`define MC_SZ_HALF 2'h1
`define MC_SZ_WORD 2'h2

// Field positions
`define MC_BIT_ROUND_ROBIN 31
`define MC_BIT_RAM_SINGLE 2
`define MC_BIT_FL_SINGLE 3
`define MC_BIT_RAM_UNCORR 6
`define MC_BIT_FL_UNCORR 7

// Implemented bits and reset values
`define MC_ECC_CFG_MASK 8'hCC
`define MC_ECC_CFG_RST 8'h00
`define MC_ECC_FLAGS_RST 8'h00
`define MC_USER_CTRL_RST 32'h00000000
`define MC_ZERO_WORD 32'h00000000
`define MC_ZERO_BYTE 8'h00

`endif

// file: mcecc_capture.v
/*
 * Capture registers for one memory: fault address, syndrome, master number,
 * attributes and data, loaded together on a single-cycle load strobe.
 * Assumes the fault fields are stable in the cycle the strobe is high.
 */
`timescale 1ns/100ps
module mcecc_capture #(
	parameter AW = 32,
	parameter DW = 32,
	parameter SW = 8,
	parameter MW = 4,
	parameter TW = 8
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Load strobe and fault fields
	input wire load,
	input wire [AW-1:0] fault_addr,
	input wire [SW-1:0] fault_syn,
	input wire [MW-1:0] fault_master,
	input wire [TW-1:0] fault_attr,
	input wire [DW-1:0] fault_data,
	// Held copies
	output reg [AW-1:0] addr_q,
	output reg [SW-1:0] syn_q,
	output reg [MW-1:0] master_q,
	output reg [TW-1:0] attr_q,
	output reg [DW-1:0] data_q
);

	// All fields load together so software sees one coherent event
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			addr_q <= {AW{1'b0}};
			syn_q <= {SW{1'b0}};
			master_q <= {MW{1'b0}};
			attr_q <= {TW{1'b0}};
			data_q <= {DW{1'b0}};
		end else if (load) begin
			addr_q <= fault_addr;
			syn_q <= fault_syn;
			master_q <= fault_master;
			attr_q <= fault_attr;
			data_q <= fault_data;
		end
	end

endmodule

// file: mcecc_ctrl.v
/*
 * Crossbar arbitration control and memory error reporting registers:
 * user control word, reporting configuration, event flags, two capture sets
 * and registered interrupt requests, behind the peripheral register bus.
 * Assumes bus requests, memory event pulses and the single-bit reporting
 * enable all come from logic on ref_clk, so none is resynchronised.
 */
// Operation
// - Control bit 31 drives crossbar round-robin select
// - Round-robin bit reset value set at build
// - Without ECC, ECC addresses are reserved
// - Eight-bit reporting configuration at offset 0x43
// - Uncorrectable error ends access with bus error
// - Interrupt covers every uncorrectable memory error; raised here only for enabled ones that win the flag
// - Single-bit enables settable only with SoC input
// - Bit 2 reports RAM single-bit corrections
// - Reported RAM event loads RAM capture registers; loaded here only when it wins the flag
// - Bit 3 reports flash single-bit corrections
// - Reported flash event loads flash capture registers; loaded here only when it wins the flag
// - Bit 6 reports RAM uncorrectable errors
// - Bit 7 reports flash uncorrectable errors
// - Reserved address access ends with error
// - Wrong-size write errors; read-only writes ignored
// - Requests are enable AND flag, then ORed
`timescale 1ns/100ps
`include "mcecc_map.vh"
module mcecc_ctrl #(
	parameter ECC_PRESENT = 1,
	parameter RR_RESET_ONE = 0,
	parameter AW = 32,
	parameter DW = 32
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Peripheral register bus
	input wire bus_req,
	input wire bus_wr,
	input wire [`MC_ADDR_W-1:0] bus_addr,
	input wire [1:0] bus_size,
	input wire [31:0] bus_wdata,
	output reg bus_ack_q,
	output reg bus_err_q,
	output reg [31:0] bus_rdata_q,
	// SoC configuration
	input wire single_report_allow,
	// RAM event reports
	input wire ram_single_evt,
	input wire ram_uncorr_evt,
	input wire [AW-1:0] ram_fault_addr,
	input wire [7:0] ram_fault_syndrome,
	input wire [3:0] ram_fault_master,
	input wire [7:0] ram_fault_attributes,
	input wire [DW-1:0] ram_fault_data,
	// Flash event reports
	input wire flash_single_evt,
	input wire flash_uncorr_evt,
	input wire [AW-1:0] flash_fault_address,
	input wire [3:0] flash_fault_master,
	input wire [7:0] flash_fault_attributes,
	input wire [DW-1:0] flash_fault_data,
	// Control outputs
	output reg [31:0] user_misc_control_q,
	output reg xbar_round_robin_q,
	// Interrupt requests
	output reg irq_single_q,
	output reg irq_ram_uncorr_q,
	output reg irq_flash_uncorr_q,
	output reg irq_uncorr_q,
	output reg irq_ecc_q
);

	localparam ECC_ON = (ECC_PRESENT != 0) ? 1'b1 : 1'b0;
	localparam RR_RST = (RR_RESET_ONE != 0) ? 1'b1 : 1'b0;

	reg [7:0] ecc_report_config_q;
	reg [7:0] ecc_report_config_d;
	reg [7:0] ecc_event_flags_q;
	reg [7:0] ecc_event_flags_d;
	reg [31:0] user_ctrl_d;
	reg ack_d;
	reg err_d;
	reg [31:0] rdata_d;
	reg [7:0] flag_clear;
	reg [7:0] flag_set;
	reg hit_user;
	reg hit_cfg;
	reg hit_flags;
	reg hit_ro;
	reg [31:0] ro_word;
	reg ram_load;
	reg flash_load;

	wire [AW-1:0] ram_addr_c;
	wire [7:0] ram_syn_c;
	wire [3:0] ram_master_c;
	wire [7:0] ram_attr_c;
	wire [DW-1:0] ram_data_c;
	wire [AW-1:0] fl_addr_c;
	wire [3:0] fl_master_c;
	wire [7:0] fl_attr_c;
	wire [DW-1:0] fl_data_c;

	// Events qualified by their reporting enables
	wire ev_ram_single = ECC_ON & ram_single_evt & ecc_report_config_q[`MC_BIT_RAM_SINGLE];
	wire ev_fl_single = ECC_ON & flash_single_evt & ecc_report_config_q[`MC_BIT_FL_SINGLE];
	wire ev_ram_uncorr = ECC_ON & ram_uncorr_evt & ecc_report_config_q[`MC_BIT_RAM_UNCORR];
	wire ev_fl_uncorr = ECC_ON & flash_uncorr_evt & ecc_report_config_q[`MC_BIT_FL_UNCORR];

	// Address decode; ECC locations vanish when the memories lack ECC
	always @* begin
		hit_user = (bus_addr == `MC_OFF_USER_CTRL);
		hit_cfg = ECC_ON & (bus_addr == `MC_OFF_ECC_CFG);
		hit_flags = ECC_ON & (bus_addr == `MC_OFF_ECC_FLAGS);
		hit_ro = 1'b0;
		ro_word = `MC_ZERO_WORD;
		if (ECC_ON) begin
			case (bus_addr)
			`MC_OFF_FL_ADDR: begin
				hit_ro = 1'b1;
				ro_word = fl_addr_c[31:0];
			end
			`MC_OFF_FL_MATTR: begin
				hit_ro = 1'b1;
				ro_word = {16'h0000, 4'h0, fl_master_c, fl_attr_c};
			end
			`MC_OFF_FL_DATA: begin
				hit_ro = 1'b1;
				ro_word = fl_data_c[31:0];
			end
			`MC_OFF_RAM_ADDR: begin
				hit_ro = 1'b1;
				ro_word = ram_addr_c[31:0];
			end
			`MC_OFF_RAM_SMATTR: begin
				hit_ro = 1'b1;
				ro_word = {8'h00, ram_syn_c, 4'h0, ram_master_c, ram_attr_c};
			end
			`MC_OFF_RAM_DATA: begin
				hit_ro = 1'b1;
				ro_word = ram_data_c[31:0];
			end
			default: begin
				hit_ro = 1'b0;
				ro_word = `MC_ZERO_WORD;
			end
			endcase
		end
	end

	// Bus transaction: response one cycle after the request
	always @* begin
		ack_d = bus_req;
		err_d = 1'b0;
		rdata_d = `MC_ZERO_WORD;
		user_ctrl_d = user_misc_control_q;
		ecc_report_config_d = ecc_report_config_q;
		flag_clear = `MC_ZERO_BYTE;
		if (bus_req) begin
			if (!(hit_user | hit_cfg | hit_flags | hit_ro)) begin
				err_d = 1'b1;
			end else if (bus_wr) begin
				if (hit_user) begin
					if (bus_size != `MC_SZ_WORD)
						err_d = 1'b1;
					else
						user_ctrl_d = bus_wdata;
				end else if (hit_cfg) begin
					if (bus_size != `MC_SZ_BYTE) begin
						err_d = 1'b1;
					end else begin
						ecc_report_config_d = bus_wdata[7:0] & `MC_ECC_CFG_MASK;
						// Single-bit enables need the SoC permission to set
						ecc_report_config_d[`MC_BIT_RAM_SINGLE] =
							bus_wdata[`MC_BIT_RAM_SINGLE] & single_report_allow;
						ecc_report_config_d[`MC_BIT_FL_SINGLE] =
							bus_wdata[`MC_BIT_FL_SINGLE] & single_report_allow;
					end
				end else if (hit_flags) begin
					if (bus_size != `MC_SZ_BYTE)
						err_d = 1'b1;
					else
						flag_clear = bus_wdata[7:0]; // Write one to clear
				end
				// Capture registers are read-only: write ignored, no error
			end else begin
				if (hit_user)
					rdata_d = user_misc_control_q;
				else if (hit_cfg)
					rdata_d = {24'h000000, ecc_report_config_q};
				else if (hit_flags)
					rdata_d = {24'h000000, ecc_event_flags_q};
				else
					rdata_d = ro_word;
			end
		end
	end

	// Only one flag stands at a time so it matches the capture registers;
	// a new event replaces the old flag and beats a same-cycle clear
	always @* begin
		flag_set = `MC_ZERO_BYTE;
		ram_load = 1'b0;
		flash_load = 1'b0;
		if (ev_ram_single) begin
			flag_set[`MC_BIT_RAM_SINGLE] = 1'b1;
			ram_load = 1'b1;
		end else if (ev_fl_single) begin
			flag_set[`MC_BIT_FL_SINGLE] = 1'b1;
			flash_load = 1'b1;
		end else if (ev_ram_uncorr) begin
			flag_set[`MC_BIT_RAM_UNCORR] = 1'b1;
			ram_load = 1'b1;
		end else if (ev_fl_uncorr) begin
			flag_set[`MC_BIT_FL_UNCORR] = 1'b1;
			flash_load = 1'b1;
		end
		if (flag_set != `MC_ZERO_BYTE)
			ecc_event_flags_d = flag_set;
		else
			ecc_event_flags_d = ecc_event_flags_q & ~flag_clear;
	end

	// Register state and bus response
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bus_ack_q <= 1'b0;
			bus_err_q <= 1'b0;
			bus_rdata_q <= `MC_ZERO_WORD;
			user_misc_control_q <= `MC_USER_CTRL_RST | {RR_RST, 31'h00000000};
			xbar_round_robin_q <= RR_RST;
			ecc_report_config_q <= `MC_ECC_CFG_RST;
			ecc_event_flags_q <= `MC_ECC_FLAGS_RST;
		end else begin
			bus_ack_q <= ack_d;
			bus_err_q <= err_d;
			bus_rdata_q <= rdata_d;
			user_misc_control_q <= user_ctrl_d;
			// The crossbar itself drops to fixed priority under elevation
			xbar_round_robin_q <= user_ctrl_d[`MC_BIT_ROUND_ROBIN];
			ecc_report_config_q <= ecc_report_config_d;
			ecc_event_flags_q <= ecc_event_flags_d;
		end
	end

	// Requests follow the next state so they rise with their flag.
	// Uncorrectable errors already end their access with a bus error in
	// the memory; this request catches those no master ever reports.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			irq_single_q <= 1'b0;
			irq_ram_uncorr_q <= 1'b0;
			irq_flash_uncorr_q <= 1'b0;
			irq_uncorr_q <= 1'b0;
			irq_ecc_q <= 1'b0;
		end else begin
			irq_single_q <= (ecc_report_config_d[`MC_BIT_RAM_SINGLE] & ecc_event_flags_d[`MC_BIT_RAM_SINGLE]) |
				(ecc_report_config_d[`MC_BIT_FL_SINGLE] & ecc_event_flags_d[`MC_BIT_FL_SINGLE]);
			irq_ram_uncorr_q <= ecc_report_config_d[`MC_BIT_RAM_UNCORR] &
				ecc_event_flags_d[`MC_BIT_RAM_UNCORR];
			irq_flash_uncorr_q <= ecc_report_config_d[`MC_BIT_FL_UNCORR] &
				ecc_event_flags_d[`MC_BIT_FL_UNCORR];
			irq_uncorr_q <= (ecc_report_config_d[`MC_BIT_RAM_UNCORR] & ecc_event_flags_d[`MC_BIT_RAM_UNCORR]) |
				(ecc_report_config_d[`MC_BIT_FL_UNCORR] & ecc_event_flags_d[`MC_BIT_FL_UNCORR]);
			irq_ecc_q <= |(ecc_report_config_d & ecc_event_flags_d);
		end
	end

	// RAM capture set
	mcecc_capture #(.AW(AW), .DW(DW), .SW(8), .MW(4), .TW(8)) u_ram_cap (
		.ref_clk(ref_clk),
		.reset(reset),
		.load(ram_load),
		.fault_addr(ram_fault_addr),
		.fault_syn(ram_fault_syndrome),
		.fault_master(ram_fault_master),
		.fault_attr(ram_fault_attributes),
		.fault_data(ram_fault_data),
		.addr_q(ram_addr_c),
		.syn_q(ram_syn_c),
		.master_q(ram_master_c),
		.attr_q(ram_attr_c),
		.data_q(ram_data_c)
	);

	// Flash capture set; flash has no syndrome, so that field stays zero
	mcecc_capture #(.AW(AW), .DW(DW), .SW(8), .MW(4), .TW(8)) u_fl_cap (
		.ref_clk(ref_clk),
		.reset(reset),
		.load(flash_load),
		.fault_addr(flash_fault_address),
		.fault_syn(`MC_ZERO_BYTE),
		.fault_master(flash_fault_master),
		.fault_attr(flash_fault_attributes),
		.fault_data(flash_fault_data),
		.addr_q(fl_addr_c),
		.syn_q(),
		.master_q(fl_master_c),
		.attr_q(fl_attr_c),
		.data_q(fl_data_c)
	);

endmodule

// file: mcecc_ctrl_props.sv
/* Checker for the reporting register block, on its top-level ports.
   Assumes one clock and the async high reset of mcecc_ctrl. */
`timescale 1ns/100ps
module mcecc_ctrl_props (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Register bus
	input wire bus_req,
	input wire bus_wr,
	input wire [6:0] bus_addr,
	input wire [1:0] bus_size,
	input wire bus_ack_q,
	input wire bus_err_q,
	input wire [31:0] bus_rdata_q,
	// Memory events
	input wire ram_single_evt,
	input wire ram_uncorr_evt,
	input wire flash_single_evt,
	input wire flash_uncorr_evt,
	// Outputs
	input wire [31:0] user_misc_control_q,
	input wire xbar_round_robin_q,
	input wire irq_single_q,
	input wire irq_ram_uncorr_q,
	input wire irq_flash_uncorr_q,
	input wire irq_uncorr_q,
	input wire irq_ecc_q
);
	// Everything here lives on the one clock
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_ack; bus_req |=> bus_ack_q; endproperty
	a_ack: assert property (p_ack) else $error("request not answered");
	property p_rr; xbar_round_robin_q == user_misc_control_q[31]; endproperty
	a_rr: assert property (p_rr) else $error("policy output differs");
	property p_rsv; bus_req && bus_addr == 7'h70 |=> bus_err_q && bus_ack_q; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved access not errored");
	property p_size; bus_req && bus_wr && bus_addr == 7'h43 && bus_size != 2'h0 |=> bus_err_q; endproperty
	a_size: assert property (p_size) else $error("wrong size write accepted");
	property p_rd43; bus_req && !bus_wr && bus_addr == 7'h43 |=> (bus_rdata_q & 32'hFFFFFF33) == 32'h0; endproperty
	a_rd43: assert property (p_rd43) else $error("unused config bit set");
	property p_or; irq_ecc_q == (irq_single_q | irq_uncorr_q) &&
		irq_uncorr_q == (irq_ram_uncorr_q | irq_flash_uncorr_q); endproperty
	a_or: assert property (p_or) else $error("combined request wrong");
	property p_ramu; $rose(irq_ram_uncorr_q) |-> $past(ram_uncorr_evt || bus_req && bus_wr); endproperty
	a_ramu: assert property (p_ramu) else $error("ram request without cause");
	property p_flu; $rose(irq_flash_uncorr_q) |-> $past(flash_uncorr_evt || bus_req && bus_wr); endproperty
	a_flu: assert property (p_flu) else $error("flash request without cause");
	property p_sgl; $rose(irq_single_q) |-> $past(ram_single_evt || flash_single_evt || bus_req && bus_wr); endproperty
	a_sgl: assert property (p_sgl) else $error("single request without cause");
	property p_fall; $fell(irq_ecc_q) |-> $past(bus_req && bus_wr); endproperty
	a_fall: assert property (p_fall) else $error("request dropped by itself");
endmodule

bind mcecc_ctrl mcecc_ctrl_props u_props (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
	.bus_wr(bus_wr), .bus_addr(bus_addr), .bus_size(bus_size), .bus_ack_q(bus_ack_q),
	.bus_err_q(bus_err_q), .bus_rdata_q(bus_rdata_q), .ram_single_evt(ram_single_evt),
	.ram_uncorr_evt(ram_uncorr_evt), .flash_single_evt(flash_single_evt),
	.flash_uncorr_evt(flash_uncorr_evt), .user_misc_control_q(user_misc_control_q),
	.xbar_round_robin_q(xbar_round_robin_q), .irq_single_q(irq_single_q),
	.irq_ram_uncorr_q(irq_ram_uncorr_q), .irq_flash_uncorr_q(irq_flash_uncorr_q),
	.irq_uncorr_q(irq_uncorr_q), .irq_ecc_q(irq_ecc_q));

// file: mcecc_mem_model.sv
/* Memory side model: one event pulse per bench command, with fault fields.
   Assumes fire is a one-cycle command on ref_clk. */
`timescale 1ns/100ps
module mcecc_mem_model #(
	parameter [31:0] FAULT_ADDR = 32'h20000040
) (
	// Clock
	input wire ref_clk,
	// Bench command
	input wire fire,
	input wire [3:0] kinds,
	// Event pulses and fault fields
	output reg [3:0] evt_q = 4'h0,
	output reg [31:0] addr_q = 32'h0
);
	// Fields are only valid with a pulse; they toggle otherwise so a late capture shows
	always @(posedge ref_clk) begin
		evt_q <= fire ? kinds : 4'h0;
		addr_q <= fire ? FAULT_ADDR : ~addr_q;
	end
endmodule

// file: tb.sv
/* Self-checking bench for mcecc_ctrl with the memory side model.
   Assumes the registered one-cycle bus answer of the design. */
`timescale 1ns/100ps
module tb;
	localparam [31:0] FA = 32'h20000040;
	reg ref_clk = 1'b0;
	reg reset = 1'b1;
	reg bus_req = 1'b0;
	reg bus_wr = 1'b0;
	reg [6:0] bus_addr = 7'h00;
	reg [1:0] bus_size = 2'h0;
	reg [31:0] bus_wdata = 32'h0;
	reg allow = 1'b1;
	reg fire = 1'b0;
	reg [3:0] kinds = 4'h0;
	reg [31:0] rd;
	reg er;
	reg er2;
	int bad_count = 0;
	int total_checks = 0;
	wire [3:0] evt;
	wire [31:0] fa, umc, rdata;
	wire ack, err, rr, irq_s, irq_ru, irq_fu, irq_u, irq_e;
	wire [31:0] umc2;
	wire err2, rr2, irq2_e;

	mcecc_ctrl dut (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .bus_wr(bus_wr),
		.bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_ack_q(ack),
		.bus_err_q(err), .bus_rdata_q(rdata), .single_report_allow(allow),
		.ram_single_evt(evt[0]), .ram_uncorr_evt(evt[2]), .ram_fault_addr(fa),
		.ram_fault_syndrome(fa[7:0]), .ram_fault_master(fa[3:0]), .ram_fault_attributes(fa[15:8]),
		.ram_fault_data(~fa), .flash_single_evt(evt[1]), .flash_uncorr_evt(evt[3]),
		.flash_fault_address(fa), .flash_fault_master(fa[7:4]), .flash_fault_attributes(fa[23:16]),
		.flash_fault_data(~fa), .user_misc_control_q(umc), .xbar_round_robin_q(rr),
		.irq_single_q(irq_s), .irq_ram_uncorr_q(irq_ru), .irq_flash_uncorr_q(irq_fu),
		.irq_uncorr_q(irq_u), .irq_ecc_q(irq_e));
	mcecc_mem_model #(.FAULT_ADDR(FA)) u_mem (.ref_clk(ref_clk), .fire(fire), .kinds(kinds),
		.evt_q(evt), .addr_q(fa));
	// Second build on the same bus: memories without ECC, round robin out of reset
	mcecc_ctrl #(.ECC_PRESENT(0), .RR_RESET_ONE(1)) dut_alt (.ref_clk(ref_clk), .reset(reset),
		.bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
		.bus_ack_q(), .bus_err_q(err2), .bus_rdata_q(), .single_report_allow(allow),
		.ram_single_evt(evt[0]), .ram_uncorr_evt(evt[2]), .ram_fault_addr(fa),
		.ram_fault_syndrome(fa[7:0]), .ram_fault_master(fa[3:0]), .ram_fault_attributes(fa[15:8]),
		.ram_fault_data(~fa), .flash_single_evt(evt[1]), .flash_uncorr_evt(evt[3]),
		.flash_fault_address(fa), .flash_fault_master(fa[7:4]), .flash_fault_attributes(fa[23:16]),
		.flash_fault_data(~fa), .user_misc_control_q(umc2), .xbar_round_robin_q(rr2),
		.irq_single_q(), .irq_ram_uncorr_q(), .irq_flash_uncorr_q(), .irq_uncorr_q(), .irq_ecc_q(irq2_e));

	initial forever #4 ref_clk = ~ref_clk;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One bus request; the answer is taken one edge later
	task xfer(input logic w, input logic [6:0] a, input logic [1:0] s, input logic [31:0] d);
		@(posedge ref_clk);
		bus_req <= 1'b1;
		bus_wr <= w;
		bus_addr <= a;
		bus_size <= s;
		bus_wdata <= d;
		@(posedge ref_clk);
		bus_req <= 1'b0;
		#1;
		chk(ack, 1'b1);
		er = err;
		er2 = err2;
		rd = rdata;
	endtask

	// Memory event; flags settle two edges after the command
	task pulse(input logic [3:0] k);
		@(posedge ref_clk);
		fire <= 1'b1;
		kinds <= k;
		@(posedge ref_clk);
		fire <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask

	task t_reset;
		chk(umc, 32'h0);
		chk(rr, 1'b0);
		chk(umc2, 32'h80000000);
		chk(rr2, 1'b1);
		xfer(0, 7'h43, 2'h0, 32'h0);
		chk(rd, 32'h0);
		$display("test reset done");
	endtask

	task t_rr;
		// No master elevates priority here, so the bit alone sets the policy
		xfer(1, 7'h24, 2'h2, 32'h80000000);
		chk(rr, 1'b1);
		chk(umc, 32'h80000000);
		xfer(1, 7'h24, 2'h1, 32'h0);
		chk({er, rr}, 2'h3);
		xfer(1, 7'h24, 2'h2, 32'h0);
		chk(rr, 1'b0);
		$display("test policy done");
	endtask

	task t_cfg;
		@(posedge ref_clk) allow <= 1'b0;
		xfer(1, 7'h43, 2'h0, 32'hFF);
		xfer(0, 7'h43, 2'h0, 32'h0);
		chk(rd, 32'hC0);
		@(posedge ref_clk) allow <= 1'b1;
		xfer(1, 7'h43, 2'h0, 32'hFF);
		xfer(1, 7'h43, 2'h2, 32'h0);
		chk(er, 1'b1);
		xfer(0, 7'h43, 2'h0, 32'h0);
		chk(rd, 32'hCC);
		$display("test config done");
	endtask

	// Each category in turn: request lines, flag, capture, then clear
	task t_evt;
		for (int i = 0; i < 4; i++) begin
			pulse(4'h1 << i);
			chk({irq_e, irq_s, irq_u, irq_ru, irq_fu}, {1'b1, i < 2, i > 1, i == 2, i == 3});
			chk(irq2_e, 1'b0);
			xfer(0, 7'h47, 2'h0, 32'h0);
			chk(rd, 32'h1 << ((i < 2) ? i + 2 : i + 4));
			xfer(0, (i % 2) ? 7'h50 : 7'h60, 2'h2, 32'h0);
			chk(rd, FA);
			xfer(0, (i % 2) ? 7'h58 : 7'h64, 2'h2, 32'h0);
			chk(rd, (i % 2) ? {20'h0, FA[7:4], FA[23:16]} : {8'h00, FA[7:0], 4'h0, FA[3:0], FA[15:8]});
			xfer(0, (i % 2) ? 7'h5C : 7'h6C, 2'h2, 32'h0);
			chk(rd, ~FA);
			xfer(1, 7'h47, 2'h0, rd & 32'h0 | 32'h1 << ((i < 2) ? i + 2 : i + 4));
			chk(irq_e, 1'b0);
		end
		$display("test events done");
	endtask

	task t_prio;
		pulse(4'hF);
		xfer(0, 7'h47, 2'h0, 32'h0);
		chk(rd, 32'h04);
		pulse(4'h8);
		xfer(0, 7'h47, 2'h0, 32'h0);
		chk(rd, 32'h80);
		xfer(1, 7'h43, 2'h0, 32'h0);
		chk(irq_e, 1'b0);
		pulse(4'h4);
		xfer(0, 7'h47, 2'h0, 32'h0);
		chk(rd, 32'h80);
		$display("test priority done");
	endtask

	task t_rsv;
		xfer(0, 7'h70, 2'h2, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		xfer(0, 7'h43, 2'h0, 32'h0);
		chk({er, er2}, 2'h1);
		xfer(1, 7'h50, 2'h2, 32'h1);
		chk(er, 1'b0);
		xfer(0, 7'h50, 2'h2, 32'h0);
		chk({er, rd}, {1'b0, FA});
		$display("test reserved done");
	endtask

	task results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Whole run is about a hundred cycles, so this only cuts a hang
	initial begin
		#20000;
		bad_count++;
		results;
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset;
		t_rr;
		t_cfg;
		t_evt;
		t_prio;
		t_rsv;
		results;
	end
endmodule
